// file: verilog/fbslave_pkg.sv
// package of register map, parameter layout and size constants
// assumes a single 10 MHz clock domain and an axi4-lite master
package fbslave_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PRM = 8'h00;
	localparam logic [7:0] ADDR_APPLY = 8'h04;
	localparam logic [7:0] ADDR_ACTIVE = 8'h08;
	localparam logic [7:0] ADDR_STATE = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_IDENT = 8'h18;

	// ----------------------------------------------------------------
	// parameter set, bit 0 is the dpv1 select
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] baud;
		logic opt;
		logic load;
		logic chan;
		logic modst;
		logic ident;
		logic tol;
		logic swap;
		logic proc;
		logic diag;
		logic dpv1;
	} prm_t;
	localparam int PRM_W = 14;
	localparam logic [PRM_W-1:0] PRM_RESET = 14'h0000;

	typedef struct packed {
		logic diag;
		logic proc;
		logic swap;
	} alarm_t;

	// ----------------------------------------------------------------
	// sizes and limits
	// ----------------------------------------------------------------
	localparam logic [3:0] BAUD_MAX = 4'h9;
	localparam logic [7:0] DIAG_HDR_LEN = 8'h06;
	localparam logic [7:0] IDENT_LEN = 8'h04;
	localparam logic [7:0] MODST_LEN = 8'h09;
	localparam logic [6:0] CHAN_MAX = 7'h5e;
	localparam logic [8:0] PRM_CLASSIC_MAX = 9'h0f0;
	localparam int C2_CONNS = 3;

	// ----------------------------------------------------------------
	// interrupt status bits
	// ----------------------------------------------------------------
	localparam int IRQ_PRM_OK = 0;
	localparam int IRQ_PRM_BAD = 1;
	localparam int IRQ_FAIL = 2;
	localparam int IRQ_LOAD = 3;
	localparam int IRQ_C2_REF = 4;
	localparam int IRQ_W = 5;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: verilog/sync2.sv
// two flip-flop synchroniser for pin levels
// assumes the inputs are quasi-static against CLK
module sync2
	import fbslave_pkg::*;
#(
	parameter int W = 1
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// file: verilog/c2_slots.sv
// slot table for acyclic class 2 connections
// assumes open and close requests are one-cycle pulses on CLK
module c2_slots
	import fbslave_pkg::*;
#(
	parameter int N = C2_CONNS
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic open_req,
	input wire logic close_req,
	input wire logic [1:0] close_id,
	output logic grant,
	output logic refuse,
	output logic [1:0] slot,
	output logic [N-1:0] busy
);
	logic [1:0] free_id;
	logic free_any;

	if (N < 1 || N > 4)
		$error("c2_slots: N must be 1 to 4");

	always_comb
	begin
		free_id = 2'h0;
		free_any = 1'b0;
		for (int i = N - 1; i >= 0; i--)
			if (!busy[i])
			begin
				free_id = 2'(i);
				free_any = 1'b1;
			end
	end

	for (genvar g = 0; g < N; g++)
	begin : g_slot
		always_ff @(posedge clk)
		begin
			if (reset)
				busy[g] <= 1'b0;
			else if (open_req && free_any && free_id == 2'(g))
				busy[g] <= 1'b1;
			else if (close_req && close_id == 2'(g))
				busy[g] <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			grant <= 1'b0;
			refuse <= 1'b0;
			slot <= 2'h0;
		end
		else
		begin
			grant <= open_req && free_any;
			refuse <= open_req && !free_any;
			if (open_req && free_any)
				slot <= free_id;
		end
	end

	a_c2_full: assert property (@(posedge clk) disable iff (reset)
		open_req && (&busy) |=> refuse && !grant)
		else $error("class 2 open not refused when all slots busy");
endmodule

// file: verilog/fbslave_core.sv
// fieldbus slave parameter, interrupt and diagnostic-frame logic
// assumes one 10 MHz clock, an axi4-lite master and same-clock
// event strobes from the link and backplane logic
//
// Contract
// - a parameter selects dpv0 or dpv1; alarms only in dpv1
// - diagnostic alarms need their own enable and dpv1
// - process alarms need their own enable and dpv1
// - swapping alarms need their own enable and dpv1
// - with mismatch tolerance, hot-swap keeps data exchange running
// - without tolerance, hot-swap fails station; mismatch stops exchange
// - identifier diagnostics off removes its 4 bytes from the frame
// - module status off removes its 9 bytes from the frame
// - channel diagnostics off removes that section, at most 94 bytes
// - load diagnostics on reports a missing load supply rail
// - one station-wide parameter enables option handling
// - exactly 3 class 2 connections may be open together
// - dpv1 accepts over 240 parameter bytes, with longer startup
// - the link runs at one of the ten listed bit rates
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
module fbslave_core
	import fbslave_pkg::*;
#(
	parameter int NCONN = C2_CONNS,
	parameter logic [15:0] IDENT_CODE = 16'h5a5a
)(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic DIAG_EVENT,
	input wire logic PROC_EVENT,
	input wire logic SWAP_EVENT,
	input wire logic MODULE_SWAP,
	input wire logic CFG_MISMATCH,
	input wire logic LOAD_SUPPLY_RAIL,
	input wire logic [6:0] CHAN_DIAG_LEN,
	input wire logic C2_OPEN,
	input wire logic C2_CLOSE,
	input wire logic [1:0] C2_CLOSE_ID,
	output logic DIAG_ALARM,
	output logic PROC_ALARM,
	output logic SWAP_ALARM,
	output logic STATION_FAIL,
	output logic DATA_EXCH,
	output logic OPTION_EN,
	output logic [3:0] BAUD_SEL,
	output logic [7:0] DIAG_LEN,
	output logic LOAD_DIAG,
	output logic C2_GRANT,
	output logic C2_REFUSE,
	output logic [1:0] C2_SLOT,
	output logic LONG_STARTUP,
	output logic IRQ
);
	prm_t staged;
	prm_t active;
	logic prm_valid;
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic wr_go;
	logic rd_go;
	logic apply_go;
	logic [8:0] apply_len;
	logic apply_ok;
	logic rail_ok;
	logic load_prev;
	logic diag_src;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [NCONN-1:0] c2_busy;
	logic [6:0] chan_len;
	logic [31:0] next_rdata;
	logic rd_hit;

	if (NCONN < 1 || NCONN > 4)
		$error("fbslave_core: NCONN must be 1 to 4");

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = data[8*b +: 8];
		return r;
	endfunction

	assign wr_go = aw_held && w_held && !BVALID;
	assign apply_go = wr_go && aw_addr == ADDR_APPLY && (&w_strb[1:0]);
	assign apply_len = w_data[8:0];
	assign apply_ok = staged.baud <= BAUD_MAX &&
		(apply_len <= PRM_CLASSIC_MAX || staged.dpv1);

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end
			else if (wr_go)
				aw_held <= 1'b0;
			if (WVALID && WREADY)
			begin
				w_held <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end
			else if (wr_go)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= RESP_OKAY;
		end
		else
		begin
			AWREADY <= !aw_held && !(AWVALID && AWREADY) &&
				!wr_go && !BVALID;
			WREADY <= !w_held && !(WVALID && WREADY) &&
				!wr_go && !BVALID;
			if (wr_go)
			begin
				BVALID <= 1'b1;
				case (aw_addr)
					ADDR_PRM, ADDR_APPLY, ADDR_IRQ_MASK:
						BRESP <= RESP_OKAY;
					default:
						BRESP <= RESP_SLVERR;
				endcase
			end
			else if (BREADY)
				BVALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// parameter staging and telegram latch
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			staged <= prm_t'(PRM_RESET);
			irq_mask <= '0;
		end
		else if (wr_go && aw_addr == ADDR_PRM)
			staged <= prm_t'(PRM_W'(merge(32'(staged), w_data, w_strb)));
		else if (wr_go && aw_addr == ADDR_IRQ_MASK && w_strb[0])
			irq_mask <= w_data[IRQ_W-1:0];
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			active <= prm_t'(PRM_RESET);
			prm_valid <= 1'b0;
			LONG_STARTUP <= 1'b0;
		end
		else if (apply_go && apply_ok)
		begin
			active <= staged;
			prm_valid <= 1'b1;
			LONG_STARTUP <= apply_len > PRM_CLASSIC_MAX;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			OPTION_EN <= 1'b0;
			BAUD_SEL <= 4'h0;
		end
		else
		begin
			OPTION_EN <= active.opt && prm_valid;
			BAUD_SEL <= active.baud;
		end
	end

	// ----------------------------------------------------------------
	// station failure and data exchange
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			STATION_FAIL <= 1'b0;
			DATA_EXCH <= 1'b0;
		end
		else
		begin
			if (MODULE_SWAP && !active.tol && prm_valid)
				STATION_FAIL <= 1'b1;
			else if (apply_go && apply_ok)
				STATION_FAIL <= 1'b0;
			DATA_EXCH <= prm_valid && !STATION_FAIL &&
				(active.tol || !CFG_MISMATCH);
		end
	end

	// ----------------------------------------------------------------
	// load supply rail and alarms
	// ----------------------------------------------------------------
	sync2 #(.W(1)) u_rail (
		.clk(CLK),
		.reset(RESET),
		.d(LOAD_SUPPLY_RAIL),
		.q(rail_ok)
	);

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			LOAD_DIAG <= 1'b0;
			load_prev <= 1'b0;
		end
		else
		begin
			LOAD_DIAG <= active.load && prm_valid && !rail_ok;
			load_prev <= LOAD_DIAG;
		end
	end

	assign diag_src = DIAG_EVENT || (LOAD_DIAG && !load_prev);

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			DIAG_ALARM <= 1'b0;
			PROC_ALARM <= 1'b0;
			SWAP_ALARM <= 1'b0;
		end
		else
		begin
			DIAG_ALARM <= diag_src && active.dpv1 && active.diag;
			PROC_ALARM <= PROC_EVENT && active.dpv1 && active.proc;
			SWAP_ALARM <= SWAP_EVENT && active.dpv1 && active.swap;
		end
	end

	// ----------------------------------------------------------------
	// diagnostic frame length
	// ----------------------------------------------------------------
	assign chan_len = CHAN_DIAG_LEN > CHAN_MAX ? CHAN_MAX : CHAN_DIAG_LEN;

	always_ff @(posedge CLK)
	begin
		if (RESET)
			DIAG_LEN <= DIAG_HDR_LEN;
		else
			DIAG_LEN <= DIAG_HDR_LEN +
				(active.ident ? IDENT_LEN : 8'h00) +
				(active.modst ? MODST_LEN : 8'h00) +
				(active.chan ? {1'b0, chan_len} : 8'h00);
	end

	// ----------------------------------------------------------------
	// class 2 connections
	// ----------------------------------------------------------------
	c2_slots #(.N(NCONN)) u_c2 (
		.clk(CLK),
		.reset(RESET),
		.open_req(C2_OPEN),
		.close_req(C2_CLOSE),
		.close_id(C2_CLOSE_ID),
		.grant(C2_GRANT),
		.refuse(C2_REFUSE),
		.slot(C2_SLOT),
		.busy(c2_busy)
	);

	// ----------------------------------------------------------------
	// interrupt status, read clears, set wins
	// ----------------------------------------------------------------
	always_comb
	begin
		irq_set = '0;
		irq_set[IRQ_PRM_OK] = apply_go && apply_ok;
		irq_set[IRQ_PRM_BAD] = apply_go && !apply_ok;
		irq_set[IRQ_FAIL] = MODULE_SWAP && !active.tol && prm_valid;
		irq_set[IRQ_LOAD] = LOAD_DIAG && !load_prev;
		irq_set[IRQ_C2_REF] = C2_REFUSE;
	end

	assign rd_go = ARVALID && ARREADY;
	assign irq_clr = (rd_go && ARADDR == ADDR_IRQ_STAT) ? irq_stat : '0;

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			irq_stat <= '0;
			IRQ <= 1'b0;
		end
		else
		begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			IRQ <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		rd_hit = 1'b1;
		case (ARADDR)
			ADDR_PRM: next_rdata = 32'(staged);
			ADDR_ACTIVE: next_rdata = {prm_valid, 17'h00000, active};
			ADDR_STATE: next_rdata = {16'h0000, 4'(c2_busy), LONG_STARTUP,
				LOAD_DIAG, DATA_EXCH, STATION_FAIL, DIAG_LEN};
			ADDR_IRQ_STAT: next_rdata = 32'(irq_stat);
			ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
			ADDR_IDENT: next_rdata = {16'h0000, IDENT_CODE};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= RESP_OKAY;
		end
		else
		begin
			ARREADY <= !RVALID && !rd_go;
			if (rd_go)
			begin
				RVALID <= 1'b1;
				RDATA <= next_rdata;
				RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (RREADY)
				RVALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_swap_notol;
		MODULE_SWAP && !active.tol && prm_valid && !apply_go;
	endsequence

	sequence s_fail_stops;
		STATION_FAIL ##1 !DATA_EXCH;
	endsequence

	a_diag_gate: assert property (@(posedge CLK) disable iff (RESET)
		DIAG_ALARM |-> $past(active.dpv1 && active.diag && diag_src))
		else $error("diagnostic alarm without dpv1 and enable");
	a_proc_gate: assert property (@(posedge CLK) disable iff (RESET)
		$rose(PROC_EVENT) && !active.dpv1 |=> !PROC_ALARM)
		else $error("process alarm issued in dpv0");
	a_swap_gate: assert property (@(posedge CLK) disable iff (RESET)
		SWAP_ALARM |-> $past(active.swap) && $past(active.dpv1))
		else $error("swapping alarm without dpv1 and enable");
	a_swap_fail: assert property (@(posedge CLK) disable iff (RESET)
		s_swap_notol |=> s_fail_stops)
		else $error("hot-swap without tolerance did not fail station");
	a_tol_keeps: assert property (@(posedge CLK) disable iff (RESET)
		active.tol && !STATION_FAIL |=> !STATION_FAIL)
		else $error("tolerant station failed on hot-swap");
	a_frame_len: assert property (@(posedge CLK) disable iff (RESET)
		!apply_go ##1 $stable(CHAN_DIAG_LEN) |=>
		$stable(DIAG_LEN) && DIAG_LEN <= 8'h71)
		else $error("diagnostic frame length wrong");
	a_load_diag: assert property (@(posedge CLK) disable iff (RESET)
		active.load && prm_valid && !rail_ok |=> LOAD_DIAG ##1
		(irq_stat[IRQ_LOAD] || $past(irq_clr[IRQ_LOAD]) || load_prev))
		else $error("missing load rail not reported");
	a_long_prm: assert property (@(posedge CLK) disable iff (RESET)
		apply_go && apply_len > PRM_CLASSIC_MAX && !staged.dpv1 |=>
		irq_stat[IRQ_PRM_BAD] && $stable(active))
		else $error("long parameter set taken in dpv0");
	a_prm_hold: assert property (@(posedge CLK) disable iff (RESET)
		!apply_go |=> $stable(active))
		else $error("parameters changed without telegram");
	a_baud_ok: assert property (@(posedge CLK) disable iff (RESET)
		BAUD_SEL <= BAUD_MAX)
		else $error("bit rate select out of range");
	a_option_one: assert property (@(posedge CLK) disable iff (RESET)
		prm_valid && $stable(active) |=> OPTION_EN == $past(active.opt))
		else $error("option handling not from station parameter");
endmodule

// file: dv/fb_master_model.sv
// fieldbus master and backplane stimulus model for the slave core
// assumes the bench calls its tasks; all drives follow a rising clk
module fb_master_model
	import fbslave_pkg::*;
(
	input wire logic clk,
	output logic diag_ev,
	output logic proc_ev,
	output logic swap_ev,
	output logic mod_swap,
	output logic mismatch,
	output logic rail,
	output logic [6:0] chan_len,
	output logic c2_open,
	output logic c2_close,
	output logic [1:0] c2_id
);
	timeunit 1ns;
	timeprecision 1ns;

	// the master may only ask for dpv1 when it runs dpv1 itself
	localparam logic DPV1_CAPABLE = 1'b1;

	initial
	begin
		{mod_swap, swap_ev, proc_ev, diag_ev} = 4'h0;
		{c2_open, c2_close, c2_id} = 4'h0;
		mismatch = 1'b0;
		rail = 1'b1;
		chan_len = 7'h00;
	end

	// one-cycle strobes: {module swap, swap, process, diagnostic}
	task automatic pulse(input logic [3:0] sel);
		@(posedge clk);
		{mod_swap, swap_ev, proc_ev, diag_ev} <= sel;
		@(posedge clk);
		{mod_swap, swap_ev, proc_ev, diag_ev} <= 4'h0;
	endtask

	// class 2 connection request strobes
	task automatic c2(input logic o, input logic c, input logic [1:0] id);
		@(posedge clk);
		{c2_open, c2_close, c2_id} <= {o, c, id};
		@(posedge clk);
		{c2_open, c2_close, c2_id} <= 4'h0;
	endtask

	task automatic levels(input logic m, input logic r, input logic [6:0] l);
		@(posedge clk);
		mismatch <= m;
		rail <= r;
		chan_len <= l;
	endtask
endmodule

// file: dv/test_fbslave_core.sv
// self-checking bench for the slave parameter and diagnostic core
// assumes fb_master_model drives the link side; axi4-lite master here
module test_fbslave_core
	import fbslave_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic [7:0] AWADDR, ARADDR, DIAG_LEN;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB, BAUD_SEL;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP, C2_SLOT, c_id;
	logic d_ev, p_ev, s_ev, m_sw, mis, rail, c_op, c_cl;
	logic [6:0] clen;
	logic DIAG_ALARM, PROC_ALARM, SWAP_ALARM, STATION_FAIL, DATA_EXCH;
	logic OPTION_EN, LOAD_DIAG, C2_GRANT, C2_REFUSE, LONG_STARTUP, IRQ;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] rng = 32'h2694;

	initial
	begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	// ident value is arbitrary
	fbslave_core #(.IDENT_CODE(16'h3c71)) u_dut (.CLK(CLK), .RESET(RESET),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .DIAG_EVENT(d_ev),
		.PROC_EVENT(p_ev), .SWAP_EVENT(s_ev), .MODULE_SWAP(m_sw),
		.CFG_MISMATCH(mis), .LOAD_SUPPLY_RAIL(rail), .CHAN_DIAG_LEN(clen),
		.C2_OPEN(c_op), .C2_CLOSE(c_cl), .C2_CLOSE_ID(c_id),
		.DIAG_ALARM(DIAG_ALARM), .PROC_ALARM(PROC_ALARM),
		.SWAP_ALARM(SWAP_ALARM), .STATION_FAIL(STATION_FAIL),
		.DATA_EXCH(DATA_EXCH), .OPTION_EN(OPTION_EN), .BAUD_SEL(BAUD_SEL),
		.DIAG_LEN(DIAG_LEN), .LOAD_DIAG(LOAD_DIAG), .C2_GRANT(C2_GRANT),
		.C2_REFUSE(C2_REFUSE), .C2_SLOT(C2_SLOT),
		.LONG_STARTUP(LONG_STARTUP), .IRQ(IRQ));

	fb_master_model u_fm (.clk(CLK), .diag_ev(d_ev), .proc_ev(p_ev),
		.swap_ev(s_ev), .mod_swap(m_sw), .mismatch(mis), .rail(rail),
		.chan_len(clen), .c2_open(c_op), .c2_close(c_cl), .c2_id(c_id));

	task automatic wrap_up;
		$display("errors %0d of %0d compares", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			error_cnt++;
			wrap_up;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// frame length: header plus the enabled optional sections
	function automatic logic [7:0] exp_len(input prm_t q, input logic [6:0] c);
		logic [7:0] n;
		n = DIAG_HDR_LEN + (q.ident ? 8'h04 : 8'h00) + (q.modst ? 8'h09 : 8'h00);
		if (q.chan)
			n = n + ((c > 7'h5e) ? 8'h5e : {1'b0, c});
		return n;
	endfunction

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		while (!(aw && w))
		begin
			@(posedge CLK);
			if (!aw && AWREADY === 1'b1)
			begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (!w && WREADY === 1'b1)
			begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end
		do @(posedge CLK); while (BVALID !== 1'b1);
		r = BRESP;
		BREADY <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (RVALID !== 1'b1);
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
	endtask

	initial
	begin
		prm_t p, act;
		logic [31:0] d;
		logic [1:0] r;
		logic [8:0] len;
		logic [6:0] cl;
		logic vld, fl, ls, m, rl;
		int i;
		RESET = 1'b1;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		{AWADDR, ARADDR, WDATA} = 48'h0;
		WSTRB = 4'hf;
		repeat (6) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		#1;
		chk(DIAG_LEN, DIAG_HDR_LEN);
		chk(DATA_EXCH, 1'b0);
		axr(ADDR_IDENT, d, r);
		chk(d[15:0], 16'h3c71);
		axr(8'h1c, d, r);
		chk(r, RESP_SLVERR);
		axw(ADDR_ACTIVE, 32'h0, r);
		chk(r, RESP_SLVERR);
		act = '0;
		{vld, fl, ls} = 3'h0;
		for (i = 0; i < 16; i++)
		begin
			d = nxt();
			p = (i == 0) ? prm_t'(14'h27ff) : prm_t'(d[13:0]);
			p.dpv1 = p.dpv1 & u_fm.DPV1_CAPABLE;
			len = (i % 4 == 0) ? 9'h0f0 : (i % 4 == 1) ? 9'h0f1 : d[22:14];
			{cl, rl, m} = d[31:23];
			u_fm.levels(m, rl, cl);
			axw(ADDR_PRM, {18'h0, p}, r);
			axw(ADDR_APPLY, {23'h0, len}, r);
			if (p.baud <= 4'h9 && (len <= 9'h0f0 || p.dpv1))
			begin
				act = p;
				{vld, fl, ls} = {2'b10, len > 9'h0f0};
			end
			repeat (6) @(posedge CLK);
			axr(ADDR_ACTIVE, d, r);
			chk(d, {vld, 17'h0, act});
			chk(DIAG_LEN, exp_len(act, cl));
			chk(OPTION_EN, act.opt);
			chk(BAUD_SEL, act.baud);
			chk(LONG_STARTUP, ls);
			chk(LOAD_DIAG, act.load & ~rl);
			chk(DATA_EXCH, vld & ~fl & (act.tol | ~m));
			for (int k = 0; k < 3; k++)
			begin
				u_fm.pulse(4'h1 << k);
				#1;
				chk({SWAP_ALARM, PROC_ALARM, DIAG_ALARM}, (4'h1 << k) &
					{act.swap, act.proc, act.diag} & {3{act.dpv1}});
			end
			u_fm.pulse(4'h8);
			#1;
			fl = fl | (vld & ~act.tol);
			chk(STATION_FAIL, fl);
			repeat (2) @(posedge CLK);
			#1;
			chk(DATA_EXCH, vld & ~fl & (act.tol | ~m));
		end
		// interrupt: unmask accepted telegrams, then read clears the bit
		u_fm.levels(1'b0, 1'b1, 7'h00);
		axr(ADDR_IRQ_STAT, d, r);
		axw(ADDR_IRQ_MASK, 32'h1, r);
		axr(ADDR_IRQ_MASK, d, r);
		chk(d[4:0], 5'h01);
		axw(ADDR_PRM, 32'h1, r);
		axw(ADDR_APPLY, 32'h10, r);
		repeat (3) @(posedge CLK);
		#1;
		chk(IRQ, 1'b1);
		axr(ADDR_IRQ_STAT, d, r);
		chk(d[0], 1'b1);
		repeat (3) @(posedge CLK);
		#1;
		chk(IRQ, 1'b0);
		axr(ADDR_IRQ_STAT, d, r);
		chk(d[0], 1'b0);
		axw(ADDR_IRQ_MASK, 32'h0, r);
		axw(ADDR_APPLY, 32'h10, r);
		repeat (3) @(posedge CLK);
		#1;
		chk(IRQ, 1'b0);
		// class 2 slots: three granted lowest first, the fourth refused
		for (i = 0; i < 4; i++)
		begin
			u_fm.c2(1'b1, 1'b0, 2'h0);
			#1;
			chk({C2_REFUSE, C2_GRANT}, (i == 3) ? 2'b10 : 2'b01);
			if (i < 3)
				chk(C2_SLOT, i[1:0]);
		end
		u_fm.c2(1'b0, 1'b1, 2'h1);
		u_fm.c2(1'b1, 1'b0, 2'h0);
		#1;
		chk({C2_GRANT, C2_SLOT}, 3'b101);
		axr(ADDR_STATE, d, r);
		chk(d[15:12], 4'h7);
		chk(d[7:0], DIAG_HDR_LEN);
		axr(ADDR_IRQ_STAT, d, r);
		chk(d[IRQ_C2_REF], 1'b1);
		wrap_up;
	end
endmodule
